// *** design/chgev_bank.sv ***
`include "chgev_defs.svh"

module chgev_bank #(
	parameter chgev_pkg::chgev_byte_t USED = `CHGEV_USED_ALL
) (
	// clock and reset
	input logic core_clk,
	input logic sys_rst,
	// flags, masks and pending summary
	chgev_bank_if.bank bus
);
	chgev_pkg::chgev_byte_t flags_ff, nxt_flags;
	chgev_pkg::chgev_byte_t masks_ff, nxt_masks;

	// ========================================================
	// sticky flags and mask register
	// a set in the clearing cycle survives, so no event is lost
	always_comb begin
		nxt_flags = flags_ff;
		if (bus.rd_clr) begin
			nxt_flags = `CHGEV_FLAG_RST; // [RQ19]
		end
		nxt_flags = (nxt_flags | bus.set_evt) & USED; // [RQ19]
		nxt_masks = masks_ff;
		if (bus.mask_we) begin
			nxt_masks = bus.mask_wdata & USED; // [RQ17]
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flags_ff <= `CHGEV_FLAG_RST;
			masks_ff <= `CHGEV_MASK_RST; // [RQ16]
		end else begin
			flags_ff <= nxt_flags;
			masks_ff <= nxt_masks;
		end
	end

	// a masked bit still latches, it only stays off the pin
	assign bus.flags = flags_ff;
	assign bus.masks = masks_ff;
	assign bus.pending = |(flags_ff & ~masks_ff); // [RQ16] [RQ20]

	// ========================================================
	// checks
	sequence s_set_seen;
		|(bus.set_evt & USED);
	endsequence

	a_set_sticks: assert property ( // [RQ19]
		@(posedge core_clk) disable iff (sys_rst)
		s_set_seen |=> ((flags_ff & $past(bus.set_evt) & USED)
			== ($past(bus.set_evt) & USED)))
		else $error("bank event pulse not latched");

	a_mask_default: assert property ( // [RQ16]
		@(posedge core_clk)
		$past(sys_rst) |-> masks_ff == `CHGEV_MASK_RST)
		else $error("bank mask not cleared by reset");

	a_flag_holds: assert property ( // [RQ19]
		@(posedge core_clk) disable iff (sys_rst)
		(!bus.rd_clr && flags_ff != 8'h00) |=> ((flags_ff
			& $past(flags_ff)) == $past(flags_ff)))
		else $error("bank flag dropped without a read");
endmodule : chgev_bank

// *** design/chgev_bank_if.sv ***
interface chgev_bank_if;
	// event pulses, clear and mask write towards a bank
	chgev_pkg::chgev_byte_t set_evt;
	logic rd_clr;
	logic mask_we;
	chgev_pkg::chgev_byte_t mask_wdata;
	// state coming back
	chgev_pkg::chgev_byte_t flags;
	chgev_pkg::chgev_byte_t masks;
	logic pending;

	modport bank (
		input set_evt, rd_clr, mask_we, mask_wdata,
		output flags, masks, pending
	);
	modport ctrl (
		output set_evt, rd_clr, mask_we, mask_wdata,
		input flags, masks, pending
	);
endinterface : chgev_bank_if

// *** design/chgev_defs.svh ***
`ifndef CHGEV_DEFS_SVH
`define CHGEV_DEFS_SVH

// ========================================================
// register offsets
`define CHGEV_EVT4_ADDR 8'h43
`define CHGEV_EVT5_ADDR 8'h44
`define CHGEV_EVT6_ADDR 8'h45
`define CHGEV_MSK4_ADDR 8'h53
`define CHGEV_MSK5_ADDR 8'h54
`define CHGEV_MSK6_ADDR 8'h55
`define CHGEV_SRC4_ADDR 8'h63
`define CHGEV_SRC5_ADDR 8'h64
`define CHGEV_SRC6_ADDR 8'h65

// ========================================================
// reset values and implemented-bit masks
`define CHGEV_FLAG_RST 8'h00
`define CHGEV_MASK_RST 8'h00
`define CHGEV_RDATA_RST 8'h00
`define CHGEV_USED_ALL 8'hFF
`define CHGEV_USED_GRP5 8'h1F

// ========================================================
// bit positions in the condition vector
`define CHGEV_C_CV 0
`define CHGEV_C_FULL 1
`define CHGEV_C_RECHG 2
`define CHGEV_C_CHG_ON 3
`define CHGEV_C_AUX_OVV 4
`define CHGEV_C_USB_OVV 5
`define CHGEV_C_HOT 6
`define CHGEV_C_COLD 7
`define CHGEV_C_SYS_OVV 8
`define CHGEV_C_WARN 9
`define CHGEV_C_TRIP 10
`define CHGEV_C_FAULT 11
`define CHGEV_C_AUX_OK 12
`define CHGEV_C_USB_OK 13
`define CHGEV_C_AUX_SAG 14
`define CHGEV_C_USB_SAG 15
`define CHGEV_NCOND 16

// ========================================================
// event bit positions inside the flag registers
`define CHGEV_B4_CV 7
`define CHGEV_B4_FULL 6
`define CHGEV_B5_SYS_OVV 4
`define CHGEV_B5_WARN_DN 3
`define CHGEV_B5_WARN_UP 2
`define CHGEV_B5_TRIP_DN 1
`define CHGEV_B5_TRIP_UP 0
`define CHGEV_B6_FAULT_DN 7
`define CHGEV_B6_FAULT_UP 6
`define CHGEV_B6_AUX_SAG 1
`define CHGEV_B6_USB_SAG 0

`endif

// *** design/chgev_pkg.sv ***
package chgev_pkg;
	// one register byte
	typedef logic [7:0] chgev_byte_t;
	// kind of register selected by an address
	typedef enum logic [1:0] {
		CHGEV_REG_NONE,
		CHGEV_REG_EVT,
		CHGEV_REG_MSK,
		CHGEV_REG_SRC
	} chgev_reg_e;
endpackage : chgev_pkg

// *** design/chgev_top.sv ***
`include "chgev_defs.svh"

//Summary of operation
// (RQ1) event on entering constant-voltage phase, live bit
// (RQ2) end of charge holds charging until resumed
// (RQ3) recharge threshold reached raises event, releases hold
// (RQ4) charging started event plus live bit
// (RQ5) aux input overvoltage event and live bit
// (RQ6) usb input overvoltage event and live bit
// (RQ7) battery too hot event and live bit
// (RQ8) battery too cold event and live bit
// (RQ9) system rail overvoltage at bit four
// (RQ10) die warning rising crossing sets event
// (RQ11) die warning falling crossing sets event
// (RQ12) shutdown crossings both ways, live bit
// (RQ13) live bit high while warning reached
// (RQ14) rise and fall events for three signals
// (RQ15) sag events when inputs reach battery level
// (RQ16) masks reset to zero, one masks event
// (RQ17) mask register sits 0x10 above events
// (RQ18) source register sits 0x20 above events
// (RQ19) event flags sticky, cleared by reading
// (RQ20) interrupt while any unmasked flag set
module chgev_top (
	// clock and reset
	input logic core_clk,
	input logic sys_rst,
	// register port
	input logic [7:0] reg_addr,
	input logic reg_wr_en,
	input logic reg_rd_en,
	input logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	// charger condition levels from the analog side
	input logic cv_phase_in,
	input logic end_of_charge_in,
	input logic recharge_level_in,
	input logic charging_in,
	input logic aux_power_input_ovv_in,
	input logic usb_power_input_ovv_in,
	input logic batt_hot_in,
	input logic batt_cold_in,
	input logic system_rail_ovv_in,
	input logic die_warn_in,
	input logic die_trip_in,
	input logic protection_fault_in,
	input logic aux_input_ok_in,
	input logic usb_input_ok_in,
	input logic aux_input_sag_in,
	input logic usb_input_sag_in,
	// host resume control and charge hold
	input logic charge_resume_req,
	output logic charge_hold,
	// interrupt pin, active high
	output logic irq
);
	localparam int NC = `CHGEV_NCOND;
	localparam int NG = 3;

	// ========================================================
	// condition synchronisers
	logic [NC-1:0] cond_raw;
	logic [NC-1:0] meta_ff, nxt_meta;
	logic [NC-1:0] sync_ff, nxt_sync;
	logic [NC-1:0] last_ff, nxt_last;
	logic [NC-1:0] rise;
	logic [NC-1:0] fall;

	// pack the pins in condition order
	assign cond_raw = {
		usb_input_sag_in, aux_input_sag_in,
		usb_input_ok_in, aux_input_ok_in,
		protection_fault_in, die_trip_in,
		die_warn_in, system_rail_ovv_in,
		batt_cold_in, batt_hot_in,
		usb_power_input_ovv_in, aux_power_input_ovv_in,
		charging_in, recharge_level_in,
		end_of_charge_in, cv_phase_in
	};

	// two sync stages plus an edge history stage, meta_ff is only read by sync_ff
	always_comb begin
		nxt_meta = cond_raw;
		nxt_sync = meta_ff;
		nxt_last = sync_ff;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
			last_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			last_ff <= nxt_last;
		end
	end

	// crossings of the synchronised levels
	assign rise = sync_ff & ~last_ff;
	assign fall = ~sync_ff & last_ff;

	// ========================================================
	// event sets and live source values per group
	chgev_pkg::chgev_byte_t set_vec [NG];
	chgev_pkg::chgev_byte_t src_vec [NG];

	// group 4: charge progress, input overvoltage, battery temp
	assign set_vec[0] = {
		rise[`CHGEV_C_CV], // [RQ1]
		rise[`CHGEV_C_FULL], // [RQ2]
		rise[`CHGEV_C_RECHG], // [RQ3]
		rise[`CHGEV_C_CHG_ON], // [RQ4]
		rise[`CHGEV_C_AUX_OVV], // [RQ5]
		rise[`CHGEV_C_USB_OVV], // [RQ6]
		rise[`CHGEV_C_HOT], // [RQ7]
		rise[`CHGEV_C_COLD] // [RQ8]
	};
	// cv live bit is the synchronised cv_phase_in level, at bit 7
	assign src_vec[0] = {
		sync_ff[`CHGEV_C_CV], sync_ff[`CHGEV_C_FULL], // [RQ1]
		sync_ff[`CHGEV_C_RECHG], sync_ff[`CHGEV_C_CHG_ON], // [RQ4]
		sync_ff[`CHGEV_C_AUX_OVV], sync_ff[`CHGEV_C_USB_OVV], // [RQ5] [RQ6]
		sync_ff[`CHGEV_C_HOT], sync_ff[`CHGEV_C_COLD] // [RQ7] [RQ8]
	};

	// group 5: rail overvoltage and die temperature crossings
	assign set_vec[1] = {
		3'b000,
		rise[`CHGEV_C_SYS_OVV], // [RQ9]
		fall[`CHGEV_C_WARN], // [RQ11]
		rise[`CHGEV_C_WARN], // [RQ10]
		fall[`CHGEV_C_TRIP], // [RQ12]
		rise[`CHGEV_C_TRIP] // [RQ12]
	};
	// both warning and both shutdown bits show one live level
	assign src_vec[1] = {
		3'b000,
		sync_ff[`CHGEV_C_SYS_OVV], // [RQ9]
		sync_ff[`CHGEV_C_WARN], sync_ff[`CHGEV_C_WARN], // [RQ13]
		sync_ff[`CHGEV_C_TRIP], sync_ff[`CHGEV_C_TRIP] // [RQ12]
	};

	// group 6: edges of fault and input-ok, input sags
	assign set_vec[2] = {
		fall[`CHGEV_C_FAULT], rise[`CHGEV_C_FAULT], // [RQ14]
		fall[`CHGEV_C_AUX_OK], rise[`CHGEV_C_AUX_OK], // [RQ14]
		fall[`CHGEV_C_USB_OK], rise[`CHGEV_C_USB_OK], // [RQ14]
		rise[`CHGEV_C_AUX_SAG], rise[`CHGEV_C_USB_SAG] // [RQ15]
	};
	assign src_vec[2] = {
		sync_ff[`CHGEV_C_FAULT], sync_ff[`CHGEV_C_FAULT],
		sync_ff[`CHGEV_C_AUX_OK], sync_ff[`CHGEV_C_AUX_OK],
		sync_ff[`CHGEV_C_USB_OK], sync_ff[`CHGEV_C_USB_OK],
		sync_ff[`CHGEV_C_AUX_SAG], sync_ff[`CHGEV_C_USB_SAG]
	};

	// ========================================================
	// address decode
	chgev_pkg::chgev_reg_e sel_kind;
	logic [1:0] sel_grp;

	// events, masks and sources share one group index
	always_comb begin
		sel_kind = chgev_pkg::CHGEV_REG_NONE;
		sel_grp = 2'd0;
		case (reg_addr)
			`CHGEV_EVT4_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_EVT;
				sel_grp = 2'd0;
			end
			`CHGEV_EVT5_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_EVT;
				sel_grp = 2'd1;
			end
			`CHGEV_EVT6_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_EVT;
				sel_grp = 2'd2;
			end
			`CHGEV_MSK4_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_MSK; // [RQ17]
				sel_grp = 2'd0;
			end
			`CHGEV_MSK5_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_MSK; // [RQ17]
				sel_grp = 2'd1;
			end
			`CHGEV_MSK6_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_MSK; // [RQ17]
				sel_grp = 2'd2;
			end
			`CHGEV_SRC4_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_SRC; // [RQ18]
				sel_grp = 2'd0;
			end
			`CHGEV_SRC5_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_SRC; // [RQ18]
				sel_grp = 2'd1;
			end
			`CHGEV_SRC6_ADDR: begin
				sel_kind = chgev_pkg::CHGEV_REG_SRC; // [RQ18]
				sel_grp = 2'd2;
			end
			default: begin
				sel_kind = chgev_pkg::CHGEV_REG_NONE;
				sel_grp = 2'd0;
			end
		endcase
	end

	// ========================================================
	// event banks
	chgev_bank_if bank_if [NG] ();
	chgev_pkg::chgev_byte_t flags_v [NG];
	chgev_pkg::chgev_byte_t masks_v [NG];
	logic [NG-1:0] pend_v;

	genvar g;
	generate
		for (g = 0; g < NG; g++) begin : g_bank
			localparam chgev_pkg::chgev_byte_t USED_G = (g == 1) ?
				`CHGEV_USED_GRP5 : `CHGEV_USED_ALL;
			assign bank_if[g].set_evt = set_vec[g];
			// reading an event register clears it
			assign bank_if[g].rd_clr = reg_rd_en
				&& sel_kind == chgev_pkg::CHGEV_REG_EVT
				&& sel_grp == 2'(g); // [RQ19]
			assign bank_if[g].mask_we = reg_wr_en
				&& sel_kind == chgev_pkg::CHGEV_REG_MSK
				&& sel_grp == 2'(g); // [RQ16] [RQ17]
			assign bank_if[g].mask_wdata = reg_wdata;
			assign flags_v[g] = bank_if[g].flags;
			assign masks_v[g] = bank_if[g].masks;
			assign pend_v[g] = bank_if[g].pending;
			chgev_bank #(
				.USED(USED_G)
			) u_bank (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.bus(bank_if[g])
			);
		end
	endgenerate

	// ========================================================
	// read data, one cycle after the strobe
	// the captured value predates the clear of that same read
	logic [7:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;

	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_rvalid = reg_rd_en;
		if (reg_rd_en) begin
			case (sel_kind)
				chgev_pkg::CHGEV_REG_EVT: nxt_rdata = flags_v[sel_grp];
				chgev_pkg::CHGEV_REG_MSK: nxt_rdata = masks_v[sel_grp];
				chgev_pkg::CHGEV_REG_SRC: nxt_rdata = src_vec[sel_grp]; // [RQ18]
				default: nxt_rdata = `CHGEV_RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_ff <= `CHGEV_RDATA_RST;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_rd_valid = rvalid_ff;

	// ========================================================
	// charge hold after end of charge
	// a fresh end-of-charge wins over a resume in the same cycle
	logic hold_ff, nxt_hold;

	always_comb begin
		nxt_hold = hold_ff;
		if (rise[`CHGEV_C_RECHG] || charge_resume_req) begin
			nxt_hold = 1'b0; // [RQ2] [RQ3]
		end
		if (rise[`CHGEV_C_FULL]) begin
			nxt_hold = 1'b1; // [RQ2]
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hold_ff <= 1'b0;
		end else begin
			hold_ff <= nxt_hold;
		end
	end

	assign charge_hold = hold_ff;

	// ========================================================
	// interrupt pin, combinational from the flag and mask flops
	assign irq = |pend_v; // [RQ20]

	// ========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_evt_read(int grp);
		reg_rd_en && sel_kind == chgev_pkg::CHGEV_REG_EVT
			&& sel_grp == 2'(grp);
	endsequence

	a_cv_event: assert property ( // [RQ1]
		$rose(cv_phase_in) ##2 rise[`CHGEV_C_CV]
			|=> flags_v[0][`CHGEV_B4_CV])
		else $error("cv entry did not set its flag");

	a_hold_set: assert property ( // [RQ2]
		rise[`CHGEV_C_FULL] |=> charge_hold && flags_v[0][`CHGEV_B4_FULL])
		else $error("end of charge did not hold charging");

	a_hold_release: assert property ( // [RQ3]
		charge_hold && !rise[`CHGEV_C_FULL]
			&& (rise[`CHGEV_C_RECHG] || charge_resume_req) |=> !charge_hold)
		else $error("charge hold not released");

	a_warn_edges: assert property ( // [RQ11]
		fall[`CHGEV_C_WARN] |=> flags_v[1][`CHGEV_B5_WARN_DN]
			&& (!flags_v[1][`CHGEV_B5_WARN_UP]
			|| $past(flags_v[1][`CHGEV_B5_WARN_UP])))
		else $error("warning fall not reported alone");

	a_trip_source: assert property ( // [RQ12]
		reg_rd_en && reg_addr == `CHGEV_SRC5_ADDR
			|=> reg_rd_valid
			&& reg_rdata[`CHGEV_B5_TRIP_UP] == $past(sync_ff[`CHGEV_C_TRIP])
			&& reg_rdata[7:5] == 3'b000)
		else $error("shutdown source bit wrong");

	a_fault_edges: assert property ( // [RQ14]
		rise[`CHGEV_C_FAULT] |=> flags_v[2][`CHGEV_B6_FAULT_UP])
		else $error("fault rising edge missed");

	a_sag_event: assert property ( // [RQ15]
		rise[`CHGEV_C_USB_SAG] |=> flags_v[2][`CHGEV_B6_USB_SAG])
		else $error("usb sag not latched");

	a_read_clears: assert property ( // [RQ19]
		s_evt_read(0) and (set_vec[0] == 8'h00) |=> flags_v[0] == 8'h00
			##0 reg_rdata == $past(flags_v[0]))
		else $error("event read did not clear or return flags");

	a_irq_follows: assert property ( // [RQ20]
		((flags_v[0] & ~masks_v[0]) == 8'h00
			&& (flags_v[1] & ~masks_v[1]) == 8'h00
			&& (flags_v[2] & ~masks_v[2]) == 8'h00) == !irq)
		else $error("interrupt pin disagrees with masked flags");

	a_mask_write: assert property ( // [RQ17]
		reg_wr_en && reg_addr == `CHGEV_MSK6_ADDR
			|=> masks_v[2] == $past(reg_wdata))
		else $error("mask write not stored");
endmodule : chgev_top

// *** testbench/chgev_host_model.sv ***
// ========================================================
// host side of the register port
module chgev_host_model (
	// clock
	input logic core_clk,
	// register port towards the block
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_wdata,
	// read answer from the block
	input logic [7:0] reg_rdata,
	input logic reg_rd_valid
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle values before the first request
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
	end

	// one-cycle write strobe; bus lines are scrambled after release so
	// a design that samples late sees garbage instead of a stale value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr

	// one-cycle read strobe; answer is taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
			output logic v);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(posedge core_clk);
		#1;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		v = reg_rd_valid;
		d = reg_rdata;
	endtask : rd
endmodule : chgev_host_model

// *** testbench/testbench.sv ***
// ========================================================
// self-checking bench for the charger event bank
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic core_clk;
	logic sys_rst;
	logic [7:0] reg_addr;
	logic reg_wr_en;
	logic reg_rd_en;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_rd_valid;
	logic [15:0] cond;
	logic charge_resume_req;
	logic charge_hold;
	logic irq;
	int errors;
	int cmp_count;
	// expected event bytes per condition index, rise and fall, and source
	logic [7:0] t_rise [16] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
		8'h02, 8'h01, 8'h10, 8'h04, 8'h01, 8'h40, 8'h10, 8'h04, 8'h02, 8'h01};
	logic [7:0] t_fall [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h08, 8'h02, 8'h80, 8'h20, 8'h08, 8'h00, 8'h00};
	logic [7:0] t_src [16] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
		8'h02, 8'h01, 8'h10, 8'h0C, 8'h03, 8'hC0, 8'h30, 8'h0C, 8'h02, 8'h01};
	logic [7:0] t_rst [10] = '{8'h43, 8'h44, 8'h45, 8'h53, 8'h54, 8'h55,
		8'h63, 8'h64, 8'h65, 8'h70};

	// ========================================================
	// clock and instances
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	chgev_top chgev_top_inst (
		.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .cv_phase_in(cond[0]),
		.end_of_charge_in(cond[1]), .recharge_level_in(cond[2]),
		.charging_in(cond[3]), .aux_power_input_ovv_in(cond[4]),
		.usb_power_input_ovv_in(cond[5]), .batt_hot_in(cond[6]),
		.batt_cold_in(cond[7]), .system_rail_ovv_in(cond[8]),
		.die_warn_in(cond[9]), .die_trip_in(cond[10]),
		.protection_fault_in(cond[11]), .aux_input_ok_in(cond[12]),
		.usb_input_ok_in(cond[13]), .aux_input_sag_in(cond[14]),
		.usb_input_sag_in(cond[15]), .charge_resume_req(charge_resume_req),
		.charge_hold(charge_hold), .irq(irq)
	);

	chgev_host_model chgev_host_model_inst (
		.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid)
	);

	// ========================================================
	// compare and access helpers
	task automatic cmp8(input string nm, input logic [7:0] e,
			input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp8

	task automatic cmp1(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp1

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		chgev_host_model_inst.rd(a, d, v);
		cmp1("reg_rd_valid", 1'b1, v);
		cmp8("reg_rdata", e, d);
	endtask : rd_chk

	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : wait_clk

	// raise then drop one condition; the live level is checked before
	// the flag read so that clear-on-read cannot hide a source fault
	task automatic edge_chk(input int c);
		logic [7:0] a;
		a = (c < 8) ? 8'h43 : ((c < 11) ? 8'h44 : 8'h45);
		cond[c] = 1'b1;
		wait_clk(4);
		cmp1("irq", 1'b1, irq);
		rd_chk(a + 8'h20, t_src[c]);
		rd_chk(a, t_rise[c]);
		cmp1("irq", 1'b0, irq);
		cond[c] = 1'b0;
		wait_clk(4);
		rd_chk(a, t_fall[c]);
		rd_chk(a, 8'h00);
	endtask : edge_chk

	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// ========================================================
	// main sequence
	initial begin
		errors = 0;
		cmp_count = 0;
		cond = 16'h0000;
		charge_resume_req = 1'b0;
		sys_rst = 1'b1;
		wait_clk(3);
		sys_rst = 1'b0;
		wait_clk(3);
		// every register and one unmapped place read zero after reset
		for (int i = 0; i < 10; i++) begin
			rd_chk(t_rst[i], 8'h00);
		end
		cmp1("irq", 1'b0, irq);
		// mask read back, group-5 upper bits drop, read-only writes lost
		chgev_host_model_inst.wr(8'h53, 8'hA5);
		rd_chk(8'h53, 8'hA5);
		chgev_host_model_inst.wr(8'h54, 8'hFF);
		rd_chk(8'h54, 8'h1F);
		chgev_host_model_inst.wr(8'h55, 8'h3C);
		rd_chk(8'h55, 8'h3C);
		chgev_host_model_inst.wr(8'h43, 8'hFF);
		rd_chk(8'h43, 8'h00);
		chgev_host_model_inst.wr(8'h63, 8'hFF);
		rd_chk(8'h63, 8'h00);
		chgev_host_model_inst.wr(8'h53, 8'h00);
		chgev_host_model_inst.wr(8'h54, 8'h00);
		chgev_host_model_inst.wr(8'h55, 8'h00);
		// each condition walked through its event and source bits
		for (int i = 0; i < 8; i++) begin
			edge_chk(i);
		end
		for (int i = 8; i < 16; i++) begin
			edge_chk(i);
		end
		// a masked event still latches but keeps the pin quiet
		chgev_host_model_inst.wr(8'h55, 8'h01);
		cond[15] = 1'b1;
		wait_clk(4);
		cmp1("irq", 1'b0, irq);
		rd_chk(8'h45, 8'h01);
		chgev_host_model_inst.wr(8'h55, 8'h00);
		// end of charge holds until resume request, then until recharge
		cond[1] = 1'b1;
		wait_clk(4);
		cmp1("charge_hold", 1'b1, charge_hold);
		charge_resume_req = 1'b1;
		wait_clk(1);
		charge_resume_req = 1'b0;
		wait_clk(2);
		cmp1("charge_hold", 1'b0, charge_hold);
		cond[1] = 1'b0;
		wait_clk(2);
		cond[1] = 1'b1;
		wait_clk(4);
		cmp1("charge_hold", 1'b1, charge_hold);
		cond[2] = 1'b1;
		wait_clk(4);
		cmp1("charge_hold", 1'b0, charge_hold);
		final_report();
	end

	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		#100000;
		errors++;
		final_report();
	end
endmodule : testbench
